// [hw/rtcmh_pkg.sv]
// constants, field layouts and states for the minute/hour/weekday timekeeping slice
// assumes one 40 MHz system clock; serial bus and oscillator pins are sampled into it
package rtcmh_pkg;
  // register byte addresses on the serial bus
  localparam logic [7:0] MIN_ADDR   = 8'h01;
  localparam logic [7:0] HOUR_ADDR  = 8'h02;
  localparam logic [7:0] DAY_OF_WEEK_COUNT_ADDR = 8'h03;
  // reset values
  localparam logic [7:0] MIN_RST    = 8'h00;
  localparam logic [7:0] HOUR_RST   = 8'h00;
  localparam logic [7:0] DAY_OF_WEEK_COUNT_RST  = 8'h01;
  // writable bit masks (bit 7 never stored)
  localparam logic [7:0] TIME_WMASK = 8'h7F;
  localparam logic [7:0] WK_WMASK   = 8'h0F;
  // bcd limits
  localparam logic [7:0] MIN_LAST    = 8'h59;
  localparam logic [7:0] HR24_LAST   = 8'h23;
  localparam logic [7:0] HR12_LAST   = 8'h12;
  localparam logic [7:0] HR12_FLIP   = 8'h11;
  localparam logic [7:0] HR12_FIRST  = 8'h01;
  localparam logic [7:0] BCD_ZERO    = 8'h00;
  localparam logic [3:0] BCD_NINE    = 4'h9;
  localparam logic [2:0] DAY_FIRST   = 3'h1;
  localparam logic [2:0] DAY_LAST    = 3'h7;
  // oscillator supervision
  localparam logic [5:0] OSC_RUN_EDGES = 6'h20;
  localparam int         SYS_CLK_MHZ   = 40;
  localparam int         OSF_TIMEOUT_US = 1000;
  localparam int         OSF_TIMEOUT_CYCLES = OSF_TIMEOUT_US * SYS_CLK_MHZ;
  // bus target address, value arbitrary
  localparam logic [6:0] DEV_ADDR = 7'h2A;
  localparam logic [2:0] BIT_LAST = 3'h7;

  // minutes register layout
  typedef struct packed {
    logic       unused;
    logic [2:0] tens;
    logic [3:0] units;
  } rtcmh_min_t;

  // hours register layout; bit 5 is afternoon flag or tens msb
  typedef struct packed {
    logic       unused;
    logic       fmt12;
    logic       pm_or_ten1;
    logic       ten0;
    logic [3:0] units;
  } rtcmh_hour_t;

  // weekday register layout
  typedef struct packed {
    logic [1:0] unused;
    logic       osc_running;
    logic       pwr_fail;
    logic       bat_en;
    logic [2:0] day;
  } rtcmh_wk_t;

  // serial engine states
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX   = 3'b001,
    ST_ACK  = 3'b010,
    ST_TX   = 3'b011,
    ST_MACK = 3'b100
  } rtcmh_state_t;

  // meaning of the byte being received
  typedef enum logic [1:0] {
    K_ADDR = 2'b00,
    K_PTR  = 2'b01,
    K_DATA = 2'b10
  } rtcmh_kind_t;
endpackage

// [hw/rtcmh_regs.sv]
// minute, hour and weekday registers with a two-wire serial target
// assumes minute_tick comes from the seconds slice on sys_clk; pins are asynchronous
`timescale 1ns/1ps

// Overview of operation
// - minute tens: bits 6-4, 0..5
// - minute units: bits 3-0, 0..9
// - bit 7 reads zero, writes ignored
// - hours bit 6 selects 12h or 24h
// - 12h: bit 5 afternoon, bit 4 tens
// - 24h: bits 5-4 hour tens 0..2
// - hour units: bits 3-0, 0..9
// - weekday write clears power failure flag
// - software never sets power failure flag
// - oscillator status: 32 edges set, timeout clears
// - all time values kept as BCD
// - end of day rolls to midnight, carries
// - weekday increments at midnight, 7 wraps 1
module rtcmh_regs #(
  parameter int OSF_TIMEOUT_CYCLES = rtcmh_pkg::OSF_TIMEOUT_CYCLES
) (
  // clock and reset
  input  wire logic sys_clk,
  input  wire logic nrst,
  // serial bus pins
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  // oscillator and power monitor pins
  input  wire logic osc_in,
  input  wire logic power_lost,
  // neighbouring slices
  input  wire logic minute_tick,
  output logic      day_carry,
  output logic      ts_clear,
  output logic      ts_log_en,
  output logic      bat_switch_en
);
  // stored registers
  rtcmh_pkg::rtcmh_min_t  minutes_count;
  rtcmh_pkg::rtcmh_hour_t hours_count;
  rtcmh_pkg::rtcmh_wk_t   weekday_and_status; // gathered from the owner flops below
  logic [2:0] wk_day;      // day of week count
  logic       wk_bat_en;   // battery enable bit
  logic       pf_flag;     // power failure flag
  logic       osc_run;     // oscillator running status
  logic [7:0] rd_byte;     // register addressed by the pointer
  // pin synchronisers; stage 1 feeds only stage 2
  logic [1:0] scl_sync;
  logic [1:0] sda_sync;
  logic [1:0] osc_sync;
  logic [1:0] pwr_sync;
  logic       scl_d;       // previous synced scl
  logic       sda_d;       // previous synced sda
  logic       osc_d;       // previous synced oscillator
  // serial engine
  rtcmh_pkg::rtcmh_state_t state;
  rtcmh_pkg::rtcmh_kind_t  kind;
  logic [2:0] bit_cnt;     // bits moved in current byte
  logic [7:0] shreg;       // receive shift
  logic [7:0] txreg;       // transmit shift
  logic [7:0] ptr;         // register pointer
  logic       reading;     // transfer direction
  logic       ack_on;      // ack slot being driven
  logic       wr_en;       // one-cycle host write
  logic [7:0] wr_addr;
  logic [7:0] wr_data;
  // oscillator and power supervision
  logic [5:0]  edge_cnt;
  logic [31:0] idle_cnt;
  logic        lost_seen;  // power loss waiting for restore

  // pin edges, taken from stage 2 onward only
  logic scl_rise, scl_fall, start_c, stop_c, osc_edge, pf_set;
  assign scl_rise = scl_sync[1] & ~scl_d;
  assign scl_fall = ~scl_sync[1] & scl_d;
  assign start_c  = scl_sync[1] & scl_d & sda_d & ~sda_sync[1];
  assign stop_c   = scl_sync[1] & scl_d & ~sda_d & sda_sync[1];
  assign osc_edge = osc_sync[1] & ~osc_d;
  assign pf_set   = lost_seen & ~pwr_sync[1];

  // bcd increment of two digits, units wrap into tens
  function automatic logic [7:0] bcd_inc(input logic [7:0] v);
    if (v[3:0] == rtcmh_pkg::BCD_NINE) begin
      bcd_inc = {v[7:4] + 4'h1, 4'h0};
    end else begin
      bcd_inc = {v[7:4], v[3:0] + 4'h1};
    end
  endfunction

  // register read decode; unmapped addresses read zero
  function automatic logic [7:0] reg_read(input logic [7:0] a);
    unique case (a)
      rtcmh_pkg::MIN_ADDR:   reg_read = minutes_count;
      rtcmh_pkg::HOUR_ADDR:  reg_read = hours_count;
      rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR: reg_read = weekday_and_status;
      default:               reg_read = 8'h00;
    endcase
  endfunction

  // read byte for the transmitter; a process so it follows register changes too
  always_comb begin
    rd_byte = reg_read(ptr);
  end

  // two-flop synchronisers plus one delayed copy for edges
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      scl_sync <= 2'h3;
      sda_sync <= 2'h3;
      osc_sync <= 2'h0;
      pwr_sync <= 2'h0;
      scl_d    <= 1'b1;
      sda_d    <= 1'b1;
      osc_d    <= 1'b0;
    end else begin
      scl_sync <= {scl_sync[0], scl_in};
      sda_sync <= {sda_sync[0], sda_in};
      osc_sync <= {osc_sync[0], osc_in};
      pwr_sync <= {pwr_sync[0], power_lost};
      scl_d    <= scl_sync[1];
      sda_d    <= sda_sync[1];
      osc_d    <= osc_sync[1];
    end
  end

  // serial target: address, pointer, data bytes with auto-increment
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      state   <= rtcmh_pkg::ST_IDLE;
      kind    <= rtcmh_pkg::K_ADDR;
      bit_cnt <= 3'h0;
      shreg   <= 8'h00;
      txreg   <= 8'h00;
      ptr     <= 8'h00;
      reading <= 1'b0;
      ack_on  <= 1'b0;
      sda_oe  <= 1'b0;
      wr_en   <= 1'b0;
      wr_addr <= 8'h00;
      wr_data <= 8'h00;
    end else begin
      wr_en <= 1'b0;
      if (stop_c) begin
        // stop releases the line
        state  <= rtcmh_pkg::ST_IDLE;
        sda_oe <= 1'b0;
      end else if (start_c) begin
        // start or repeated start restarts addressing
        state   <= rtcmh_pkg::ST_RX;
        kind    <= rtcmh_pkg::K_ADDR;
        bit_cnt <= 3'h0;
        ack_on  <= 1'b0;
        sda_oe  <= 1'b0;
      end else begin
        unique case (state)
          rtcmh_pkg::ST_IDLE: begin
            sda_oe <= 1'b0;
          end
          rtcmh_pkg::ST_RX: begin
            if (scl_rise) begin
              shreg   <= {shreg[6:0], sda_sync[1]};
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == rtcmh_pkg::BIT_LAST) begin
                state <= rtcmh_pkg::ST_ACK;
                unique case (kind)
                  rtcmh_pkg::K_ADDR: begin
                    // foreign address: stay off the bus
                    if (shreg[6:0] != rtcmh_pkg::DEV_ADDR) begin
                      state <= rtcmh_pkg::ST_IDLE;
                    end
                    reading <= sda_sync[1];
                    kind    <= rtcmh_pkg::K_PTR;
                  end
                  rtcmh_pkg::K_PTR: begin
                    ptr  <= {shreg[6:0], sda_sync[1]};
                    kind <= rtcmh_pkg::K_DATA;
                  end
                  default: begin
                    wr_en   <= 1'b1;
                    wr_addr <= ptr;
                    wr_data <= {shreg[6:0], sda_sync[1]};
                    ptr     <= ptr + 8'h01;
                  end
                endcase
              end
            end
          end
          rtcmh_pkg::ST_ACK: begin
            if (scl_fall) begin
              if (!ack_on) begin
                // pull low through the ack bit
                ack_on <= 1'b1;
                sda_oe <= 1'b1;
              end else if (reading) begin
                // load the read byte, msb first; sampled at the first edge of the read
                ack_on  <= 1'b0;
                txreg   <= {rd_byte[6:0], 1'b0};
                sda_oe  <= ~rd_byte[7];
                ptr     <= ptr + 8'h01;
                bit_cnt <= 3'h0;
                state   <= rtcmh_pkg::ST_TX;
              end else begin
                ack_on  <= 1'b0;
                sda_oe  <= 1'b0;
                bit_cnt <= 3'h0;
                state   <= rtcmh_pkg::ST_RX;
              end
            end
          end
          rtcmh_pkg::ST_TX: begin
            if (scl_fall) begin
              bit_cnt <= bit_cnt + 3'h1;
              if (bit_cnt == rtcmh_pkg::BIT_LAST) begin
                sda_oe <= 1'b0;
                state  <= rtcmh_pkg::ST_MACK;
              end else begin
                sda_oe <= ~txreg[7];
                txreg  <= {txreg[6:0], 1'b0};
              end
            end
          end
          rtcmh_pkg::ST_MACK: begin
            // host nack ends the read, ack loads the next byte on the fall
            if (scl_rise) begin
              if (sda_sync[1]) begin
                state <= rtcmh_pkg::ST_IDLE;
              end else begin
                ack_on <= 1'b1;
                state  <= rtcmh_pkg::ST_ACK;
              end
            end
          end
          default: begin
            state <= rtcmh_pkg::ST_IDLE;
          end
        endcase
      end
    end
  end

  // open-drain data: only ever drives low
  always_ff @(posedge sys_clk) begin
    sda_out <= 1'b0;
  end

  // time counting and host writes; a host write wins over a tick in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      minutes_count   <= rtcmh_pkg::MIN_RST;
      hours_count     <= rtcmh_pkg::HOUR_RST;
      wk_day          <= rtcmh_pkg::DAY_OF_WEEK_COUNT_RST[2:0];
      wk_bat_en       <= 1'b0;
      day_carry       <= 1'b0;
    end else begin
      day_carry <= 1'b0;
      if (minute_tick) begin
        if (minutes_count == rtcmh_pkg::MIN_LAST) begin
          minutes_count <= rtcmh_pkg::BCD_ZERO;
          if (hours_count.fmt12) begin
            // 12-hour: 11 flips afternoon, 12 goes to 1
            if ({3'h0, hours_count[4:0]} == rtcmh_pkg::HR12_LAST) begin
              hours_count[4:0] <= rtcmh_pkg::HR12_FIRST[4:0];
            end else if ({3'h0, hours_count[4:0]} == rtcmh_pkg::HR12_FLIP) begin
              hours_count[4:0]      <= rtcmh_pkg::HR12_LAST[4:0];
              hours_count.pm_or_ten1 <= ~hours_count.pm_or_ten1;
              day_carry             <= hours_count.pm_or_ten1;
            end else begin
              hours_count[4:0] <= 5'(bcd_inc({3'h0, hours_count[4:0]}));
            end
          end else if ({2'h0, hours_count[5:0]} == rtcmh_pkg::HR24_LAST) begin
            hours_count[5:0] <= rtcmh_pkg::BCD_ZERO[5:0];
            day_carry        <= 1'b1;
          end else begin
            hours_count[5:0] <= 6'(bcd_inc({2'h0, hours_count[5:0]}));
          end
        end else begin
          minutes_count <= bcd_inc(minutes_count);
        end
      end
      // weekday advances on the carry from the previous cycle
      if (day_carry) begin
        wk_day <= (wk_day == rtcmh_pkg::DAY_LAST) ? rtcmh_pkg::DAY_FIRST : wk_day + 3'h1;
      end
      if (wr_en) begin
        unique case (wr_addr)
          rtcmh_pkg::MIN_ADDR:  minutes_count <= wr_data & rtcmh_pkg::TIME_WMASK;
          rtcmh_pkg::HOUR_ADDR: hours_count   <= wr_data & rtcmh_pkg::TIME_WMASK;
          rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR: begin
            wk_day    <= wr_data[2:0];
            wk_bat_en <= wr_data[3];
          end
          default: begin
            // unmapped writes are dropped
          end
        endcase
      end
    end
  end

  // status byte gathered from its owners; each field keeps a single driver
  always_comb begin
    weekday_and_status.unused      = 2'h0;
    weekday_and_status.osc_running = osc_run;
    weekday_and_status.pwr_fail    = pf_flag;
    weekday_and_status.bat_en      = wk_bat_en;
    weekday_and_status.day         = wk_day;
  end

  // power failure flag: only the monitor sets it, a weekday write clears it unless the monitor sets it in the same cycle
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      lost_seen <= 1'b0;
      pf_flag   <= 1'b0;
      ts_clear  <= 1'b0;
      ts_log_en <= 1'b1;
    end else begin
      if (pwr_sync[1]) begin
        lost_seen <= 1'b1;
      end else if (lost_seen) begin
        lost_seen <= 1'b0;
      end
      ts_clear <= 1'b0;
      if (pf_set) begin
        pf_flag <= 1'b1;
      end else if (wr_en && wr_addr == rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR) begin
        pf_flag  <= 1'b0;
        ts_clear <= pf_flag;
      end
      // timestamps log only while the flag is clear
      ts_log_en <= ~(pf_set | (pf_flag & ~(wr_en && wr_addr == rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR)));
    end
  end

  // oscillator running status from edge count and idle timeout
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      edge_cnt <= 6'h00;
      idle_cnt <= 32'h0;
      osc_run  <= 1'b0;
    end else if (osc_edge) begin
      idle_cnt <= 32'h0;
      if (edge_cnt != rtcmh_pkg::OSC_RUN_EDGES) begin
        edge_cnt <= edge_cnt + 6'h01;
      end
      if (edge_cnt == rtcmh_pkg::OSC_RUN_EDGES - 6'h01) begin
        osc_run <= 1'b1;
      end
    end else if (idle_cnt >= 32'(OSF_TIMEOUT_CYCLES)) begin
      edge_cnt <= 6'h00;
      osc_run  <= 1'b0;
    end else begin
      idle_cnt <= idle_cnt + 32'h1;
    end
  end

  // battery switchover permission follows the enable bit
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      bat_switch_en <= 1'b0;
    end else begin
      bat_switch_en <= weekday_and_status.bat_en;
    end
  end

  // checks
  a_bit7_zero: assert property (@(posedge sys_clk) disable iff (!nrst)
    !minutes_count[7] && !hours_count[7] && weekday_and_status.unused == 2'h0)
    else $error("unimplemented bit 7 set");
  a_min_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    minute_tick && !wr_en && minutes_count == 8'h59 |=> minutes_count == 8'h00)
    else $error("minutes did not wrap");
  a_min_units: assert property (@(posedge sys_clk) disable iff (!nrst)
    minute_tick && !wr_en && minutes_count.units != 4'h9
    |=> minutes_count.units == $past(minutes_count.units) + 4'h1)
    else $error("minute units not incremented");
  a_day_rollover: assert property (@(posedge sys_clk) disable iff (!nrst)
    minute_tick && !wr_en && minutes_count == 8'h59 && hours_count == 8'h23
    |=> hours_count == 8'h00 && day_carry)
    else $error("24h day rollover wrong");
  a_noon_flip: assert property (@(posedge sys_clk) disable iff (!nrst)
    minute_tick && !wr_en && minutes_count == 8'h59 && hours_count == 8'h51
    |=> hours_count == 8'h72 && !day_carry)
    else $error("12h noon flip wrong");
  a_week_wrap: assert property (@(posedge sys_clk) disable iff (!nrst)
    day_carry && !wr_en && weekday_and_status.day == 3'h7 |=> weekday_and_status.day == 3'h1)
    else $error("weekday wrap wrong");
  a_pf_write_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
    wr_en && wr_addr == 8'h03 && !pf_set |=> !weekday_and_status.pwr_fail ##1 ts_log_en)
    else $error("weekday write left flag set");
  a_pf_no_soft_set: assert property (@(posedge sys_clk) disable iff (!nrst)
    !weekday_and_status.pwr_fail && !pf_set |=> !weekday_and_status.pwr_fail)
    else $error("power flag set without power loss");
  a_osc_start: assert property (@(posedge sys_clk) disable iff (!nrst)
    osc_edge && edge_cnt == 6'h1F |=> weekday_and_status.osc_running)
    else $error("oscillator status not set after 32 edges");
  a_bat_follow: assert property (@(posedge sys_clk) disable iff (!nrst)
    $rose(weekday_and_status.bat_en) |=> bat_switch_en)
    else $error("switchover enable did not follow");
endmodule

// [test/rtcmh_host.sv]
// host controller model driving the two-wire bus of the timekeeping slice
// assumes a pull-up on sda; the bench resolves the wire from both enables
`timescale 1ns/1ps
module rtcmh_host (
  // clock
  input  wire logic sys_clk,
  // bus
  input  wire logic sda,
  output logic      scl,
  output logic      host_oe
);
  localparam int HALF = 8; // half bus period in sys_clk, twice the minimum

  // bus idles released, scl parked high
  initial begin
    scl     = 1'b1;
    host_oe = 1'b0;
  end

  // wait half a bus period, step just after the edge
  task automatic half();
    repeat (HALF) @(posedge sys_clk);
    #1;
  endtask

  // hold sda two edges past the scl fall so no false start is seen
  task automatic low();
    repeat (2) @(posedge sys_clk);
    #1;
  endtask

  // start or repeated start: sda falls while scl high
  task automatic start();
    host_oe = 1'b0;
    half();
    scl = 1'b1;
    half();
    host_oe = 1'b1;
    half();
    scl = 1'b0;
    low();
  endtask

  // one bit; the wire is sampled at the last edge of the high phase
  task automatic bit_io(input logic b, output logic s);
    host_oe = ~b;
    half();
    scl = 1'b1;
    repeat (HALF) @(posedge sys_clk);
    s = sda;
    #1;
    scl = 1'b0;
    low();
  endtask

  // stop: sda rises while scl high
  task automatic stop();
    host_oe = 1'b1;
    half();
    scl = 1'b1;
    half();
    host_oe = 1'b0;
    half();
  endtask

  // byte out msb first, then the target's acknowledge bit
  task automatic send(input logic [7:0] d, output logic ack_n);
    logic s;
    for (int i = 7; i >= 0; i--) bit_io(d[i], s);
    bit_io(1'b1, ack_n);
  endtask

  // byte in msb first; last byte is refused with a nack
  task automatic recv(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, s);
      d[i] = s;
    end
    bit_io(last, s);
  endtask

  // one register write; ack_n high if any byte was refused
  task automatic write_reg(input logic [7:0] ptr, input logic [7:0] d, output logic ack_n);
    logic a0, a1, a2;
    start();
    send({rtcmh_pkg::DEV_ADDR, 1'b0}, a0);
    send(ptr, a1);
    send(d, a2);
    stop();
    ack_n = a0 | a1 | a2;
  endtask

  // pointer set, repeated start, one byte read
  task automatic read_reg(input logic [6:0] dev, input logic [7:0] ptr, output logic [7:0] d, output logic ack_n);
    logic a0, a1, a2;
    start();
    send({dev, 1'b0}, a0);
    send(ptr, a1);
    start();
    send({dev, 1'b1}, a2);
    recv(1'b1, d);
    stop();
    ack_n = a0 | a1 | a2;
  endtask
endmodule

// [test/rtcmh_regs_test.sv]
// self-checking bench for the minute, hour and weekday slice
// assumes the host model owns scl; sda is a pulled-up wire resolved here
`timescale 1ns/1ps
module rtcmh_regs_test;
  localparam int TMO = 200; // shortened oscillator timeout, keeps the run brief
  // clock, reset and pins
  logic       sys_clk     = 1'b0;
  logic       nrst        = 1'b0;
  logic       osc_in      = 1'b0;
  logic       osc_on      = 1'b0;
  logic       power_lost  = 1'b0;
  logic       minute_tick = 1'b0;
  logic       scl, host_oe, sda_out, sda_oe, day_carry, ts_clear, ts_log_en, bat_switch_en;
  wire        sda = ~(sda_oe | host_oe); // pull-up, either party pulls low
  // bench counters and reference model
  int         n_mismatch  = 0;
  int         check_count = 0;
  int         n_carry     = 0;
  int         n_clr       = 0;
  int         m_min = 0, m_hour = 0, m_wk = 1, m_flag = 0, m_osc = 0, m_carry = 0, m_clr = 0;
  int         min_tab[6]  = '{8'h09, 8'h59, 8'h59, 8'h59, 8'h59, 8'h59};
  int         hr_tab[6]   = '{8'h05, 8'h19, 8'h23, 8'h71, 8'h51, 8'h52};
  logic [7:0] rd;
  logic       nak;

  always #12.5 sys_clk = ~sys_clk;

  rtcmh_regs #(.OSF_TIMEOUT_CYCLES(TMO)) rtcmh_regs_i (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda), .sda_out(sda_out), .sda_oe(sda_oe),
    .osc_in(osc_in), .power_lost(power_lost), .minute_tick(minute_tick), .day_carry(day_carry),
    .ts_clear(ts_clear), .ts_log_en(ts_log_en), .bat_switch_en(bat_switch_en));
  rtcmh_host rtcmh_host_i (.sys_clk(sys_clk), .sda(sda), .scl(scl), .host_oe(host_oe));

  // oscillator stand-in, 1 us period instead of the crystal rate
  always begin
    repeat (20) @(posedge sys_clk);
    #1;
    if (osc_on) osc_in = ~osc_in;
  end

  // count the single-cycle pulses to neighbouring slices
  always @(posedge sys_clk) begin
    if (day_carry === 1'b1) n_carry++;
    if (ts_clear === 1'b1) n_clr++;
  end

  // compare one value
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test();
    if (n_mismatch == 0 && check_count > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // register write, every byte must be acknowledged
  task automatic wr(input logic [7:0] ptr, input logic [7:0] d);
    rtcmh_host_i.write_reg(ptr, d, nak);
    check("write ack", {7'h00, nak}, 8'h00);
  endtask

  // register read compared with the model
  task automatic rd_chk(input string what, input logic [7:0] ptr, input int exp);
    rtcmh_host_i.read_reg(rtcmh_pkg::DEV_ADDR, ptr, rd, nak);
    check("read ack", {7'h00, nak}, 8'h00);
    check(what, rd, 8'(exp));
  endtask

  function automatic int bcd_inc(input int x);
    return ((x & 15) == 9) ? (x & 8'hF0) + 16 : x + 1;
  endfunction

  function automatic int wk_exp();
    return (m_osc << 5) | (m_flag << 4) | m_wk;
  endfunction

  // reference for one minute step, carrying through hours into weekday
  task automatic model_tick();
    int f12, pm, h;
    f12 = (m_hour >> 6) & 1;
    pm  = f12 & (m_hour >> 5);
    h   = f12 ? (m_hour & 8'h1F) : (m_hour & 8'h3F);
    if (m_min != 8'h59) begin
      m_min = bcd_inc(m_min);
      return;
    end
    m_min = 0;
    if (f12 == 0 && h == 8'h23) h = 0;
    else if (f12 == 1 && h == 8'h12) h = 1;
    else if (f12 == 1 && h == 8'h11) begin
      h  = 8'h12;
      pm = 1 - pm;
    end else h = bcd_inc(h);
    // midnight only: 00 in 24h, 12 AM reached from 11 PM in 12h
    if ((f12 == 0 && h == 0) || (f12 == 1 && h == 8'h12 && pm == 0)) begin
      m_carry++;
      m_wk = (m_wk & 8'h08) | (((m_wk & 7) == 7) ? 1 : (m_wk & 7) + 1);
    end
    m_hour = (f12 << 6) | (pm << 5) | h;
  endtask

  // one minute pulse, then time for the carry chain to settle
  task automatic tick();
    minute_tick = 1'b1;
    @(posedge sys_clk);
    #1;
    minute_tick = 1'b0;
    repeat (6) @(posedge sys_clk);
    #1;
    model_tick();
  endtask

  // main sequence
  initial begin
    int v;
    void'($urandom(32'h5a513526));
    repeat (8) @(posedge sys_clk);
    #1;
    nrst = 1'b1;
    repeat (4) @(posedge sys_clk);
    #1;
    check("log enable at reset", {7'h00, ts_log_en}, 8'h01);
    check("data drive level", {7'h00, sda_out}, 8'h00);
    rd_chk("minutes reset", rtcmh_pkg::MIN_ADDR, m_min);
    rd_chk("hours reset", rtcmh_pkg::HOUR_ADDR, m_hour);
    rd_chk("weekday reset", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
    // random legal values, bit 7 and status bits forced high on write
    for (int i = 0; i < 4; i++) begin
      m_min = ($urandom_range(5) << 4) | $urandom_range(9);
      wr(rtcmh_pkg::MIN_ADDR, 8'(m_min | 8'h80));
      rd_chk("minutes", rtcmh_pkg::MIN_ADDR, m_min);
      if (i < 2) m_hour = ($urandom_range(1) << 4) | $urandom_range(9);
      else m_hour = 8'h40 | ($urandom_range(1) << 5) | $urandom_range(9, 1);
      wr(rtcmh_pkg::HOUR_ADDR, 8'(m_hour | 8'h80));
      rd_chk("hours", rtcmh_pkg::HOUR_ADDR, m_hour);
      v = $urandom_range(7, 1) | ($urandom_range(1) << 3);
      m_wk = v;
      wr(rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, 8'(v | 8'hF0));
      rd_chk("weekday", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
      check("battery switchover", {7'h00, bat_switch_en}, 8'(v >> 3));
    end
    // bcd steps, end of day in both formats, noon and 12 AM
    m_wk = 8'h0F;
    wr(rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, 8'h0F);
    for (int i = 0; i < 6; i++) begin
      m_min  = min_tab[i];
      m_hour = hr_tab[i];
      wr(rtcmh_pkg::MIN_ADDR, 8'(m_min));
      wr(rtcmh_pkg::HOUR_ADDR, 8'(m_hour));
      tick();
      rd_chk("minutes step", rtcmh_pkg::MIN_ADDR, m_min);
      rd_chk("hours step", rtcmh_pkg::HOUR_ADDR, m_hour);
      rd_chk("weekday step", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
      check("day carries", 8'(n_carry), 8'(m_carry));
    end
    // power lost and restored sets the flag; any weekday write clears it
    power_lost = 1'b1;
    repeat (10) @(posedge sys_clk);
    #1;
    power_lost = 1'b0;
    repeat (10) @(posedge sys_clk);
    #1;
    m_flag = 1;
    check("log enable in failure", {7'h00, ts_log_en}, 8'h00);
    rd_chk("flag set", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
    for (int i = 0; i < 2; i++) begin
      m_wk = 8'h0A;
      m_clr = m_clr + m_flag;
      m_flag = 0;
      wr(rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, 8'h1A);
      rd_chk("flag cleared", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
      check("timestamp clears", 8'(n_clr), 8'(m_clr));
      check("log enable", {7'h00, ts_log_en}, 8'h01);
    end
    // oscillator status rises after 32 edges, falls after the timeout
    osc_on = 1'b1;
    m_osc = 1;
    rd = 8'h00;
    for (int i = 0; i < 20 && rd[5] !== 1'b1; i++) begin
      rtcmh_host_i.read_reg(rtcmh_pkg::DEV_ADDR, rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, rd, nak);
    end
    check("oscillator running", rd, 8'(wk_exp()));
    if (rd[5] !== 1'b1) end_of_test();
    osc_on = 1'b0;
    repeat (TMO + 50) @(posedge sys_clk);
    #1;
    m_osc = 0;
    rd_chk("oscillator stopped", rtcmh_pkg::DAY_OF_WEEK_COUNT_ADDR, wk_exp());
    // refusal of a foreign target address; an unmapped pointer is acknowledged and reads zero
    rtcmh_host_i.read_reg(rtcmh_pkg::DEV_ADDR ^ 7'h01, rtcmh_pkg::MIN_ADDR, rd, nak);
    check("foreign address", {7'h00, nak}, 8'h01);
    rd_chk("unmapped pointer", 8'h10, 0);
    end_of_test();
  end
endmodule
